// *** eiod_decoder.sv ***
`timescale 1ns/1ps
// Operation
// - Primary 011111, extended opcode bits 21-30
// - 01111 01011 is signed divide
// - 10000 00000 moves exception summary to condition
// - Carrying subtract/add with overflow recording
// - 10000 10110 is byte-reversed word load
// - Logical and arithmetic right shifts
// - Translation buffer operations
// - 10011 01000 is negate with overflow
// - Subtract-from-extended with overflow
// - Add-extended with overflow
// - Indexed and immediate string stores
// - Byte-reversed word and halfword transfers
// - Zero-extended subtract/add with overflow
// - Minus-one-extended subtract/add with overflow
// - Multiply low and add with overflow
// - Cache block operations
// - Halfword and byte sign extension
// - Unsigned and signed divide with overflow
// - Accept 16-bit compressed instructions
// - Short branches to link/count register
// - Short returns, sync and system call
module eiod_decoder
  import eiod_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic i_is_short,
  input wire logic [31:0] i_instr,
  output logic o_valid,
  output eiod_op_t o_op,
  output logic o_condition_field_update,
  output logic o_overflow_flag_update,
  output logic o_uses_carry_input,
  output logic o_illegal
);

  // Reset synchroniser stages.
  logic rst_meta_ff;
  logic rst_sync_ff;
  // Registered copies of the decode, one per output.
  logic o_valid_ff;
  eiod_op_t op_ff;
  logic rc_ff;
  logic ov_ff;
  logic ca_ff;
  logic illegal_ff;

  // Next values from the combinational decode.
  eiod_op_t nxt_op;
  logic nxt_rc;
  logic nxt_ov;
  logic nxt_ca;
  logic nxt_illegal;
  logic [9:0] xo;
  logic rc_bit;
  logic [15:0] half;
  logic [5:0] primary;

  // Reset is released through two flops so every register leaves reset on the same edge.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Instruction bit n counts from the most significant end, so bit n is i_instr[31-n].
  assign xo = i_instr[31-XO_LSB +: 10];
  assign rc_bit = i_instr[31-RC_BIT];
  // A short instruction sits in the upper halfword, as fetched.
  assign half = i_instr[31:16];
  // Primary opcode, instruction bits 0 to 5.
  assign primary = i_instr[31:26];

  // Combinational decode; the record bit is only honoured where the encoding defines it.
  always_comb begin
    nxt_op = EIOD_OP_NONE;
    nxt_rc = 1'b0;
    nxt_ov = 1'b0;
    nxt_ca = 1'b0;
    if (i_is_short) begin
      // Only the control forms with twelve zero upper bits are decoded here.
      if (half[15:4] == 12'h000) begin
        unique case (half[3:0])
          // Branches through the link and count registers.
          C_BLR: nxt_op = EIOD_OP_SHORT_BRANCH_LINK_REG;
          C_BLRL: nxt_op = EIOD_OP_SHORT_BRANCH_LINK_REG_LINKED;
          C_BCTR: nxt_op = EIOD_OP_SHORT_BRANCH_COUNT_REG;
          C_BCTRL: nxt_op = EIOD_OP_SHORT_BRANCH_COUNT_REG_LINKED;

          // Interrupt returns, then sync and system call.
          C_RFI: nxt_op = EIOD_OP_SHORT_INTERRUPT_RETURN;
          C_RFCI: nxt_op = EIOD_OP_SHORT_CRITICAL_RETURN;
          C_RFDI: nxt_op = EIOD_OP_SHORT_DEBUG_RETURN;
          C_ISYNC: nxt_op = EIOD_OP_SHORT_INSTRUCTION_SYNC;
          C_SYSCALL: nxt_op = EIOD_OP_SHORT_SYSTEM_CALL;
          default: nxt_op = EIOD_OP_NONE;
        endcase
      end
    end else if (primary == PRIMARY_RR) begin
      // Honour the record bit by default; forms whose last bit is reserved clear it again.
      nxt_rc = rc_bit;
      unique case (xo)
        // Bitwise NAND, record bit honoured.
        XO_NAND: nxt_op = EIOD_OP_NAND;

        // Signed divide without overflow recording.
        XO_DIVW: nxt_op = EIOD_OP_DIVW;

        // Exception summary copy; its last bit is reserved.
        XO_MOVE_XER: begin
          nxt_op = EIOD_OP_MOVE_XER;
          nxt_rc = 1'b0;
        end

        // Carrying forms set the carry but never read it, so only overflow is flagged.
        XO_SUBFCO: begin
          nxt_op = EIOD_OP_SUBFC;
          nxt_ov = 1'b1;
        end
        XO_ADDCO: begin
          nxt_op = EIOD_OP_ADDC;
          nxt_ov = 1'b1;
        end

        // Byte-reversed word load.
        XO_LWBR: begin
          nxt_op = EIOD_OP_LWBR;
          nxt_rc = 1'b0;
        end

        // Right shifts, each with a record variant.
        XO_SRW: nxt_op = EIOD_OP_SRW;
        XO_SRAW: nxt_op = EIOD_OP_SRAW;
        XO_SRAWI: nxt_op = EIOD_OP_SRAWI;

        // Translation-buffer maintenance never records a condition.
        XO_TLB_SYNC: begin
          nxt_op = EIOD_OP_TLB_SYNC;
          nxt_rc = 1'b0;
        end
        XO_TLB_INVAL: begin
          nxt_op = EIOD_OP_TLB_INVAL;
          nxt_rc = 1'b0;
        end
        XO_TLB_SEARCH: begin
          nxt_op = EIOD_OP_TLB_SEARCH;
          nxt_rc = 1'b0;
        end
        XO_TLB_READ: begin
          nxt_op = EIOD_OP_TLB_READ;
          nxt_rc = 1'b0;
        end
        XO_TLB_WRITE: begin
          nxt_op = EIOD_OP_TLB_WRITE;
          nxt_rc = 1'b0;
        end

        // Negate with overflow recording.
        XO_NEGO: begin
          nxt_op = EIOD_OP_NEG;
          nxt_ov = 1'b1;
        end

        // Extended subtract consumes the carry input.
        XO_SUBFEO: begin
          nxt_op = EIOD_OP_SUBFE;
          nxt_ov = 1'b1;
          nxt_ca = 1'b1;
        end

        // Extended add consumes the carry input.
        XO_ADDEO: begin
          nxt_op = EIOD_OP_ADDE;
          nxt_ov = 1'b1;
          nxt_ca = 1'b1;
        end

        // Multi-byte string stores.
        XO_STSWX: begin
          nxt_op = EIOD_OP_STSWX;
          nxt_rc = 1'b0;
        end
        XO_STSWI: begin
          nxt_op = EIOD_OP_STSWI;
          nxt_rc = 1'b0;
        end

        // Byte-reversed indexed word and halfword transfers.
        XO_STWBR: begin
          nxt_op = EIOD_OP_STWBR;
          nxt_rc = 1'b0;
        end
        XO_STHBR: begin
          nxt_op = EIOD_OP_STHBR;
          nxt_rc = 1'b0;
        end
        XO_LHBR: begin
          nxt_op = EIOD_OP_LHBR;
          nxt_rc = 1'b0;
        end

        // Zero-extended forms combine the carry input with zero.
        XO_SUBFZEO: begin
          nxt_op = EIOD_OP_SUBFZE;
          nxt_ov = 1'b1;
          nxt_ca = 1'b1;
        end
        XO_ADDZEO: begin
          nxt_op = EIOD_OP_ADDZE;
          nxt_ov = 1'b1;
          nxt_ca = 1'b1;
        end

        // Minus-one-extended forms combine the carry input with all ones.
        XO_SUBFMEO: begin
          nxt_op = EIOD_OP_SUBFME;
          nxt_ov = 1'b1;
          nxt_ca = 1'b1;
        end
        XO_ADDMEO: begin
          nxt_op = EIOD_OP_ADDME;
          nxt_ov = 1'b1;
          nxt_ca = 1'b1;
        end

        // Low multiply and plain add, both with overflow recording.
        XO_MULLWO: begin
          nxt_op = EIOD_OP_MULLW;
          nxt_ov = 1'b1;
        end
        XO_ADDO: begin
          nxt_op = EIOD_OP_ADD;
          nxt_ov = 1'b1;
        end

        // Cache block operations carry no record bit.
        XO_DCB_ALLOC: begin
          nxt_op = EIOD_OP_DCB_ALLOC;
          nxt_rc = 1'b0;
        end
        XO_ICB_INVAL: begin
          nxt_op = EIOD_OP_ICB_INVAL;
          nxt_rc = 1'b0;
        end
        XO_DCB_ZERO: begin
          nxt_op = EIOD_OP_DCB_ZERO;
          nxt_rc = 1'b0;
        end

        // Sign extensions, each with a record variant.
        XO_EXTSH: nxt_op = EIOD_OP_EXTSH;
        XO_EXTSB: nxt_op = EIOD_OP_EXTSB;

        // Divides with overflow recording; signed shares its identity with plain divide.
        XO_DIVWUO: begin
          nxt_op = EIOD_OP_DIVWU;
          nxt_ov = 1'b1;
        end
        XO_DIVWO: begin
          nxt_op = EIOD_OP_DIVW;
          nxt_ov = 1'b1;
        end

        // Anything else in this range is left for the illegal flag.
        default: begin
          nxt_op = EIOD_OP_NONE;
          nxt_rc = 1'b0;
        end
      endcase
    end
  end

  // Valid follows the offered word with exactly one cycle of latency.
  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      o_valid_ff <= 1'b0;
    end else begin
      o_valid_ff <= i_valid;
    end
  end

  // The identity is captured every cycle; consumers qualify it with valid.
  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      op_ff <= EIOD_OP_NONE;
    end else begin
      op_ff <= nxt_op;
    end
  end

  // Condition-field recording, already cleared for forms whose last bit is reserved.
  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rc_ff <= 1'b0;
    end else begin
      rc_ff <= nxt_rc;
    end
  end

  // Overflow recording for the forms that define it.
  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ov_ff <= 1'b0;
    end else begin
      ov_ff <= nxt_ov;
    end
  end

  // Carry-input use for the extended, zero-extended and minus-one-extended forms.
  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ca_ff <= 1'b0;
    end else begin
      ca_ff <= nxt_ca;
    end
  end

  // A word is illegal only when it was really offered and nothing matched it.
  assign nxt_illegal = i_valid && (nxt_op == EIOD_OP_NONE);

  // Unknown words are flagged rather than dropped, so the exception logic can trap them.
  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      illegal_ff <= 1'b0;
    end else begin
      illegal_ff <= nxt_illegal;
    end
  end

  // Every output is a flop, so the execute stage never sees decode glitches.
  assign o_valid = o_valid_ff;
  assign o_op = op_ff;
  assign o_condition_field_update = rc_ff;
  assign o_overflow_flag_update = ov_ff;
  assign o_uses_carry_input = ca_ff;
  assign o_illegal = illegal_ff;

endmodule

// *** eiod_decoder_properties.sv ***
`timescale 1ns/1ps
// Ties each registered decoder output to the word taken one edge earlier.
module eiod_decoder_checker
  import eiod_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic i_is_short,
  input wire logic [31:0] i_instr,
  input wire logic o_valid,
  input wire eiod_op_t o_op,
  input wire logic o_condition_field_update,
  input wire logic o_overflow_flag_update,
  input wire logic o_uses_carry_input,
  input wire logic o_illegal
);
  logic [1:0] up_ff;
  logic rr_w;
  logic [9:0] xo_w;
  // Outputs lag release by the reset synchroniser, so checks wait until it has drained.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up_ff <= 2'h0;
    end else if (up_ff != 2'h3) begin
      up_ff <= up_ff + 2'h1;
    end
  end
  // A valid 32-bit word with the shared primary opcode, and its extended field.
  assign rr_w = i_valid && !i_is_short && (i_instr[31:26] == PRIMARY_RR);
  assign xo_w = i_instr[10:1];
  default clocking dflt @(posedge i_clk); endclocking
  default disable iff (!i_rst_n || up_ff != 2'h3);
  property p_idle_quiet;
    !$past(i_valid) |-> !o_valid && !o_illegal;
  endproperty
  property p_illegal_none;
    o_illegal |-> o_valid && o_op == EIOD_OP_NONE;
  endproperty
  property p_primary;
    $past(i_valid && !i_is_short && i_instr[31:26] != PRIMARY_RR) |-> o_illegal;
  endproperty
  property p_nand;
    $past(rr_w && xo_w == XO_NAND) |->
      o_op == EIOD_OP_NAND && o_condition_field_update == $past(i_instr[0]);
  endproperty
  property p_divwo;
    $past(rr_w && xo_w == XO_DIVWO) |-> o_op == EIOD_OP_DIVW && o_overflow_flag_update
      && o_condition_field_update == $past(i_instr[0]);
  endproperty
  property p_addeo;
    $past(rr_w && xo_w == XO_ADDEO) |->
      o_op == EIOD_OP_ADDE && o_overflow_flag_update && o_uses_carry_input;
  endproperty
  property p_lwbr;
    $past(rr_w && xo_w == XO_LWBR) |-> o_op == EIOD_OP_LWBR && !o_condition_field_update;
  endproperty
  property p_short_blr;
    $past(i_valid && i_is_short && i_instr[31:16] == 16'h0004) |->
      o_op == EIOD_OP_SHORT_BRANCH_LINK_REG && !o_illegal;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("output without valid word");
  a_illegal_none: assert property (p_illegal_none) else $error("illegal with identity");
  a_primary: assert property (p_primary) else $error("foreign primary not illegal");
  a_nand: assert property (p_nand) else $error("nand decode wrong");
  a_divwo: assert property (p_divwo) else $error("signed divide decode wrong");
  a_addeo: assert property (p_addeo) else $error("add extended decode wrong");
  a_lwbr: assert property (p_lwbr) else $error("reversed load decode wrong");
  a_short_blr: assert property (p_short_blr) else $error("short branch decode wrong");
  c_divwo: cover property (o_op == EIOD_OP_DIVW && o_overflow_flag_update);
  c_illegal: cover property (o_illegal);
  c_burst: cover property (o_valid ##1 o_valid ##1 o_valid);
endmodule

bind eiod_decoder eiod_decoder_checker u_chk (.i_clk, .i_rst_n, .i_valid, .i_is_short,
  .i_instr, .o_valid, .o_op, .o_condition_field_update, .o_overflow_flag_update,
  .o_uses_carry_input, .o_illegal);

// *** eiod_exec_model.sv ***
`timescale 1ns/1ps
// Execute-side stand-in: retires decoded words and traps on illegal ones.
module eiod_exec_model (
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic i_illegal,
  output int o_issued,
  output int o_traps
);
  // It never stalls, since the decoder offers no back-pressure to honour.
  initial begin
    o_issued = 0;
    o_traps = 0;
  end
  always @(posedge i_clk) begin
    if (i_valid && i_illegal) begin
      o_traps <= o_traps + 1;
    end else if (i_valid) begin
      o_issued <= o_issued + 1;
    end
  end
endmodule

// *** eiod_pkg.sv ***
package eiod_pkg;
  // Primary opcode of the 32-bit register-register format.
  localparam logic [5:0] PRIMARY_RR = 6'h1F;
  // Field positions, counted with bit 0 as the most significant instruction bit.
  localparam int XO_MSB = 21;
  localparam int XO_LSB = 30;
  localparam int RC_BIT = 31;
  // Ten-bit extended opcodes (record bit excluded).
  localparam logic [9:0] XO_NAND = 10'h1DC;
  localparam logic [9:0] XO_DIVW = 10'h1EB;
  localparam logic [9:0] XO_MOVE_XER = 10'h200;
  localparam logic [9:0] XO_SUBFCO = 10'h208;
  localparam logic [9:0] XO_ADDCO = 10'h20A;
  localparam logic [9:0] XO_LWBR = 10'h216;
  localparam logic [9:0] XO_SRW = 10'h218;
  localparam logic [9:0] XO_TLB_SYNC = 10'h236;
  localparam logic [9:0] XO_NEGO = 10'h268;
  localparam logic [9:0] XO_SUBFEO = 10'h288;
  localparam logic [9:0] XO_ADDEO = 10'h28A;
  localparam logic [9:0] XO_STSWX = 10'h295;
  localparam logic [9:0] XO_STWBR = 10'h296;
  localparam logic [9:0] XO_SUBFZEO = 10'h2C8;
  localparam logic [9:0] XO_ADDZEO = 10'h2CA;
  localparam logic [9:0] XO_STSWI = 10'h2D5;
  localparam logic [9:0] XO_SUBFMEO = 10'h2E8;
  localparam logic [9:0] XO_ADDMEO = 10'h2EA;
  localparam logic [9:0] XO_MULLWO = 10'h2EB;
  localparam logic [9:0] XO_DCB_ALLOC = 10'h2F6;
  localparam logic [9:0] XO_ADDO = 10'h30A;
  localparam logic [9:0] XO_TLB_INVAL = 10'h312;
  localparam logic [9:0] XO_LHBR = 10'h316;
  localparam logic [9:0] XO_SRAW = 10'h318;
  localparam logic [9:0] XO_SRAWI = 10'h338;
  localparam logic [9:0] XO_TLB_SEARCH = 10'h392;
  localparam logic [9:0] XO_STHBR = 10'h396;
  localparam logic [9:0] XO_EXTSH = 10'h39A;
  localparam logic [9:0] XO_TLB_READ = 10'h3B2;
  localparam logic [9:0] XO_EXTSB = 10'h3BA;
  localparam logic [9:0] XO_DIVWUO = 10'h3CB;
  localparam logic [9:0] XO_TLB_WRITE = 10'h3D2;
  localparam logic [9:0] XO_ICB_INVAL = 10'h3D6;
  localparam logic [9:0] XO_DIVWO = 10'h3EB;
  localparam logic [9:0] XO_DCB_ZERO = 10'h3F6;
  // Low nibbles of the 16-bit control forms whose upper twelve bits are zero.
  localparam logic [3:0] C_ISYNC = 4'h1;
  localparam logic [3:0] C_SYSCALL = 4'h2;
  localparam logic [3:0] C_BLR = 4'h4;
  localparam logic [3:0] C_BLRL = 4'h5;
  localparam logic [3:0] C_BCTR = 4'h6;
  localparam logic [3:0] C_BCTRL = 4'h7;
  localparam logic [3:0] C_RFI = 4'h8;
  localparam logic [3:0] C_RFCI = 4'h9;
  localparam logic [3:0] C_RFDI = 4'hA;

  // Decoded instruction identity.
  typedef enum logic [5:0] {
    EIOD_OP_NONE, EIOD_OP_NAND, EIOD_OP_DIVW, EIOD_OP_MOVE_XER, EIOD_OP_SUBFC, EIOD_OP_ADDC,
    EIOD_OP_LWBR, EIOD_OP_SRW, EIOD_OP_TLB_SYNC, EIOD_OP_NEG, EIOD_OP_SUBFE, EIOD_OP_ADDE,
    EIOD_OP_STSWX, EIOD_OP_STWBR, EIOD_OP_SUBFZE, EIOD_OP_ADDZE, EIOD_OP_STSWI,
    EIOD_OP_SUBFME, EIOD_OP_ADDME, EIOD_OP_MULLW, EIOD_OP_DCB_ALLOC, EIOD_OP_ADD,
    EIOD_OP_TLB_INVAL, EIOD_OP_LHBR, EIOD_OP_SRAW, EIOD_OP_SRAWI, EIOD_OP_TLB_SEARCH,
    EIOD_OP_STHBR, EIOD_OP_EXTSH, EIOD_OP_TLB_READ, EIOD_OP_EXTSB, EIOD_OP_DIVWU,
    EIOD_OP_TLB_WRITE, EIOD_OP_ICB_INVAL, EIOD_OP_DCB_ZERO,
    EIOD_OP_SHORT_BRANCH_LINK_REG, EIOD_OP_SHORT_BRANCH_LINK_REG_LINKED,
    EIOD_OP_SHORT_BRANCH_COUNT_REG, EIOD_OP_SHORT_BRANCH_COUNT_REG_LINKED,
    EIOD_OP_SHORT_INTERRUPT_RETURN, EIOD_OP_SHORT_CRITICAL_RETURN,
    EIOD_OP_SHORT_DEBUG_RETURN, EIOD_OP_SHORT_INSTRUCTION_SYNC, EIOD_OP_SHORT_SYSTEM_CALL
  } eiod_op_t;
endpackage

// *** tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  checked++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); \
  end
module tb;
  import eiod_pkg::*;
  logic i_clk, i_rst_n, i_valid, i_is_short, o_valid, o_cf, o_ov, o_ca, o_illegal;
  logic [31:0] i_instr;
  eiod_op_t o_op;
  int fail_count = 0;
  int checked = 0;
  int issued, traps, exp_issued = 0, exp_traps = 0;
  // Entry: extended opcode, expected overflow, carry and record use, then identity.
  localparam logic [18:0] RR_TBL [35] = '{
    {XO_NAND,3'h1,EIOD_OP_NAND},{XO_DIVW,3'h1,EIOD_OP_DIVW},{XO_MOVE_XER,3'h0,EIOD_OP_MOVE_XER},
    {XO_SUBFCO,3'h5,EIOD_OP_SUBFC},{XO_ADDCO,3'h5,EIOD_OP_ADDC},{XO_LWBR,3'h0,EIOD_OP_LWBR},
    {XO_SRW,3'h1,EIOD_OP_SRW},{XO_TLB_SYNC,3'h0,EIOD_OP_TLB_SYNC},{XO_NEGO,3'h5,EIOD_OP_NEG},
    {XO_SUBFEO,3'h7,EIOD_OP_SUBFE},{XO_ADDEO,3'h7,EIOD_OP_ADDE},{XO_STSWX,3'h0,EIOD_OP_STSWX},
    {XO_STWBR,3'h0,EIOD_OP_STWBR},{XO_SUBFZEO,3'h7,EIOD_OP_SUBFZE},{XO_ADDZEO,3'h7,EIOD_OP_ADDZE},
    {XO_STSWI,3'h0,EIOD_OP_STSWI},{XO_SUBFMEO,3'h7,EIOD_OP_SUBFME},{XO_ADDMEO,3'h7,EIOD_OP_ADDME},
    {XO_MULLWO,3'h5,EIOD_OP_MULLW},{XO_DCB_ALLOC,3'h0,EIOD_OP_DCB_ALLOC},
    {XO_ADDO,3'h5,EIOD_OP_ADD},{XO_TLB_INVAL,3'h0,EIOD_OP_TLB_INVAL},{XO_LHBR,3'h0,EIOD_OP_LHBR},
    {XO_SRAW,3'h1,EIOD_OP_SRAW},{XO_SRAWI,3'h1,EIOD_OP_SRAWI},
    {XO_TLB_SEARCH,3'h0,EIOD_OP_TLB_SEARCH},{XO_STHBR,3'h0,EIOD_OP_STHBR},
    {XO_EXTSH,3'h1,EIOD_OP_EXTSH},{XO_TLB_READ,3'h0,EIOD_OP_TLB_READ},
    {XO_EXTSB,3'h1,EIOD_OP_EXTSB},{XO_DIVWUO,3'h5,EIOD_OP_DIVWU},
    {XO_TLB_WRITE,3'h0,EIOD_OP_TLB_WRITE},{XO_ICB_INVAL,3'h0,EIOD_OP_ICB_INVAL},
    {XO_DIVWO,3'h5,EIOD_OP_DIVW},{XO_DCB_ZERO,3'h0,EIOD_OP_DCB_ZERO}};

  eiod_decoder dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
    .i_is_short(i_is_short), .i_instr(i_instr), .o_valid(o_valid), .o_op(o_op),
    .o_condition_field_update(o_cf), .o_overflow_flag_update(o_ov),
    .o_uses_carry_input(o_ca), .o_illegal(o_illegal));
  eiod_exec_model u_exec (.i_clk(i_clk), .i_valid(o_valid), .i_illegal(o_illegal),
    .o_issued(issued), .o_traps(traps));

  // Free-running core clock.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic end_of_test;
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Drives a word at the falling edge; the next falling edge sees its registered decode.
  task automatic send(input logic v, input logic s, input logic [31:0] w, input eiod_op_t op,
      input logic [2:0] flg, input logic ill);
    i_valid = v;
    i_is_short = s;
    i_instr = w;
    @(negedge i_clk);
    `CHK("valid", v, o_valid)
    `CHK("op", op, o_op)
    `CHK("overflow", flg[2], o_ov)
    `CHK("carry", flg[1], o_ca)
    `CHK("record", flg[0], o_cf)
    `CHK("illegal", ill, o_illegal)
    if (v && ill) exp_traps++;
    else if (v) exp_issued++;
  endtask

  function automatic eiod_op_t short_op(input logic [3:0] n);
    case (n)
      C_ISYNC: return EIOD_OP_SHORT_INSTRUCTION_SYNC;
      C_SYSCALL: return EIOD_OP_SHORT_SYSTEM_CALL;
      C_BLR: return EIOD_OP_SHORT_BRANCH_LINK_REG;
      C_BLRL: return EIOD_OP_SHORT_BRANCH_LINK_REG_LINKED;
      C_BCTR: return EIOD_OP_SHORT_BRANCH_COUNT_REG;
      C_BCTRL: return EIOD_OP_SHORT_BRANCH_COUNT_REG_LINKED;
      C_RFI: return EIOD_OP_SHORT_INTERRUPT_RETURN;
      C_RFCI: return EIOD_OP_SHORT_CRITICAL_RETURN;
      C_RFDI: return EIOD_OP_SHORT_DEBUG_RETURN;
      default: return EIOD_OP_NONE;
    endcase
  endfunction

  // Every extended opcode back to back, both record settings, with busy register fields.
  task automatic t_rr;
    logic [18:0] e;
    for (int i = 0; i < 35; i++) begin
      for (int rc = 0; rc < 2; rc++) begin
        e = RR_TBL[i];
        send(1'b1, 1'b0, {6'h1F, 15'h2A5A, e[18:9], rc[0]}, eiod_op_t'(e[5:0]),
          {e[8:7], e[6] & rc[0]}, 1'b0);
      end
    end
  endtask

  // All sixteen low nibbles of the zero-prefixed short control forms.
  task automatic t_short;
    for (int n = 0; n < 16; n++) begin
      send(1'b1, 1'b1, {12'h000, n[3:0], 16'h0000}, short_op(n[3:0]), 3'h0,
        short_op(n[3:0]) == EIOD_OP_NONE);
    end
  endtask

  // Foreign primary, unknown extended opcode, and an idle slot.
  task automatic t_illegal;
    send(1'b1, 1'b0, {6'h1E, 15'h0000, XO_ADDO, 1'b1}, EIOD_OP_NONE, 3'h0, 1'b1);
    send(1'b1, 1'b0, {6'h1F, 15'h0000, 10'h3FF, 1'b0}, EIOD_OP_NONE, 3'h0, 1'b1);
    send(1'b0, 1'b0, {6'h1E, 15'h0000, XO_ADDO, 1'b0}, EIOD_OP_NONE, 3'h0, 1'b0);
  endtask

  // A reset in mid-run clears the outputs; decoding resumes after the synchroniser.
  task automatic t_reset;
    i_rst_n = 1'b0;
    i_valid = 1'b1;
    i_is_short = 1'b0;
    i_instr = {6'h1F, 15'h0000, XO_ADDO, 1'b1};
    @(negedge i_clk);
    `CHK("reset valid", 1'b0, o_valid)
    `CHK("reset op", EIOD_OP_NONE, o_op)
    i_valid = 1'b0;
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_clk);
    send(1'b1, 1'b0, {6'h1F, 15'h0000, XO_DIVWO, 1'b1}, EIOD_OP_DIVW, 3'h5, 1'b0);
    // The execute model counts a word at the edge after it stands, so let that edge pass.
    i_valid = 1'b0;
    @(negedge i_clk);
    `CHK("issued", exp_issued, issued)
    `CHK("traps", exp_traps, traps)
  endtask

  // Watchdog: the whole sequence needs about one hundred cycles.
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end

  initial begin
    i_rst_n = 1'b0;
    i_valid = 1'b0;
    i_is_short = 1'b0;
    i_instr = 32'h0000_0000;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_clk);
    t_rr();
    t_short();
    t_illegal();
    t_reset();
    end_of_test();
  end
endmodule
